//--- qtm_pkg.sv
// package: register map, field layouts and types of the queue map and traffic meter
`default_nettype none
package qtm_pkg;
    // register byte offsets
    localparam logic [7:0] QTM_CTRL_OFS   = 8'h00;
    localparam logic [7:0] QTM_CRATE_OFS  = 8'h04;
    localparam logic [7:0] QTM_PRATE_OFS  = 8'h08;
    localparam logic [7:0] QTM_CBS_OFS    = 8'h0C;
    localparam logic [7:0] QTM_EBS_OFS    = 8'h10;
    localparam logic [7:0] QTM_CTOK_OFS   = 8'h14;
    localparam logic [7:0] QTM_ETOK_OFS   = 8'h18;
    localparam logic [7:0] QTM_STAT_OFS   = 8'h1C;
    // control field positions
    localparam int QTM_CTRL_EN_BIT    = 0;
    localparam int QTM_CTRL_MODE_LSB  = 1;
    localparam int QTM_CTRL_SRC_LSB   = 3;
    localparam int QTM_CTRL_SHAPE_BIT = 5;
    localparam int QTM_CTRL_GACT_BIT  = 6;
    localparam int QTM_CTRL_RACT_BIT  = 7;
    localparam int QTM_CTRL_GDSCP_LSB = 8;
    localparam int QTM_CTRL_RDSCP_LSB = 14;
    localparam int QTM_CTRL_YDSCP_LSB = 20;
    // reset values
    localparam logic [31:0] QTM_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] QTM_RATE_RST = 32'h0000_0001;
    localparam logic [31:0] QTM_BS_RST   = 32'h0000_2800;
    // rate accumulator: tokens per cycle in 16.16 fixed point
    localparam int QTM_FRAC_BITS = 16;
    // length thresholds for length based queue choice
    localparam logic [15:0] QTM_LEN_HI = 16'h044C;
    localparam logic [15:0] QTM_LEN_LO = 16'h00FA;
    localparam logic [2:0]  QTM_Q_LOW  = 3'h0;

    typedef enum logic [1:0] {QTM_M_TB = 2'h0, QTM_M_SR = 2'h1, QTM_M_TR = 2'h3} qtm_mode_t;
    typedef enum logic [1:0] {QTM_S_UP = 2'h0, QTM_S_PREC = 2'h1, QTM_S_DSCP = 2'h3,
                              QTM_S_LEN = 2'h2} qtm_src_t;
    typedef enum logic [1:0] {QTM_GREEN = 2'h0, QTM_YELLOW = 2'h1, QTM_RED = 2'h2} qtm_color_t;

    typedef struct packed {
        logic [2:0]  upri;
        logic [7:0]  tos;
        logic [15:0] len;
        logic        classed;
        logic [2:0]  class_q;
    } qtm_pkt_t;

    typedef struct packed {
        logic [2:0]  queue;
        qtm_color_t  color;
        logic        drop;
        logic        remark;
        logic [5:0]  dscp;
        logic [15:0] len;
    } qtm_res_t;
endpackage : qtm_pkg
`default_nettype wire

//--- qtm_top.sv
// module: priority queue assignment and token bucket / three-colour traffic meter
`default_nettype none
module qtm_top
    import qtm_pkg::*;
#(
    parameter int TOK_W = 32
) (
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr,
    input  wire logic        i_pkt_valid,
    input  wire qtm_pkt_t    i_pkt,
    output logic             o_pkt_ready,
    output logic             o_res_valid,
    output qtm_res_t         o_res,
    input  wire logic        i_res_ready
);
    logic [31:0]      ctrl_r;
    logic [31:0]      crate_r;
    logic [31:0]      prate_r;
    logic [TOK_W-1:0] cbs_r;
    logic [TOK_W-1:0] ebs_r;
    logic [TOK_W-1:0] ctok_r;
    logic [TOK_W-1:0] etok_r;
    logic [QTM_FRAC_BITS-1:0] cfrac_r;
    logic [QTM_FRAC_BITS-1:0] pfrac_r;
    logic [31:0]      n_green_r;
    logic [31:0]      n_red_r;

    qtm_mode_t  mode;
    qtm_src_t   src;
    logic       qos_en;
    logic       shape;
    assign qos_en = ctrl_r[QTM_CTRL_EN_BIT];
    assign mode   = qtm_mode_t'(ctrl_r[QTM_CTRL_MODE_LSB +: 2]);
    assign src    = qtm_src_t'(ctrl_r[QTM_CTRL_SRC_LSB +: 2]);
    assign shape  = ctrl_r[QTM_CTRL_SHAPE_BIT];

    // dscp code point to queue
    function automatic logic [2:0] dscp_queue(input logic [5:0] cp);
        logic [2:0] q;
        q = QTM_Q_LOW;
        unique case (cp[5:3])
            3'h1: q = cp[0] ? QTM_Q_LOW : 3'h3;
            3'h2: q = cp[0] ? QTM_Q_LOW : 3'h4;
            3'h3: q = cp[0] ? QTM_Q_LOW : 3'h5;
            3'h4: q = cp[0] ? QTM_Q_LOW : 3'h6;
            3'h5: q = (cp[2:0] == 3'h0 || cp[2:0] == 3'h6) ? 3'h6 : QTM_Q_LOW;
            3'h6: q = (cp[2:0] == 3'h0) ? 3'h7 : QTM_Q_LOW;
            3'h7: q = (cp[2:0] == 3'h0) ? 3'h7 : QTM_Q_LOW;
            default: q = QTM_Q_LOW;
        endcase
        return q;
    endfunction : dscp_queue

    function automatic logic [2:0] auto_queue(input qtm_pkt_t p, input qtm_src_t s);
        logic [2:0] q;
        logic [2:0] prec;
        prec = p.tos[7:5];
        q    = QTM_Q_LOW;
        unique case (s)
            QTM_S_UP:
                unique case (p.upri)
                    3'h0:    q = 3'h2;
                    3'h1:    q = 3'h0;
                    3'h2:    q = 3'h1;
                    default: q = p.upri;
                endcase
            QTM_S_PREC:
                unique case (prec)
                    3'h0:    q = QTM_Q_LOW;
                    3'h1:    q = 3'h3;
                    3'h2:    q = 3'h4;
                    3'h3:    q = 3'h5;
                    3'h4,
                    3'h5:    q = 3'h6;
                    default: q = 3'h7;
                endcase
            QTM_S_DSCP: q = dscp_queue(p.tos[7:2]);
            QTM_S_LEN:
                if (p.len > QTM_LEN_HI)
                    q = 3'h2;
                else if (p.len >= QTM_LEN_LO)
                    q = 3'h3;
                else
                    q = 3'h5;
        endcase
        return q;
    endfunction : auto_queue

    // meter decision, combinational on the head packet
    logic [TOK_W-1:0] plen;
    logic             c_ok;
    logic             e_ok;
    qtm_color_t       color;
    logic             hold;
    logic             take;
    assign plen = TOK_W'(i_pkt.len);
    assign c_ok = ctok_r >= plen;
    assign e_ok = etok_r >= plen;

    always_comb
    begin
        color = QTM_RED;
        unique case (mode)
            QTM_M_TB: color = c_ok ? QTM_GREEN : QTM_RED;
            QTM_M_SR: color = c_ok ? QTM_GREEN : (e_ok ? QTM_YELLOW : QTM_RED);
            QTM_M_TR: color = !e_ok ? QTM_RED : (c_ok ? QTM_GREEN : QTM_YELLOW);
            default:  color = QTM_RED;
        endcase
    end

    // shaping stalls the source instead of marking, in token bucket mode only; output stage must be free too
    assign hold = qos_en && mode == QTM_M_TB && shape && !c_ok;
    assign take = i_pkt_valid && (!o_res_valid || i_res_ready) && !hold;

    logic res_drop;
    assign res_drop = qos_en && color == QTM_RED && !ctrl_r[QTM_CTRL_RACT_BIT];

    // token refill and charge; excess/peak bucket reuses etok_r
    logic [TOK_W+QTM_FRAC_BITS:0] cacc;
    logic [TOK_W+QTM_FRAC_BITS:0] pacc;
    logic [TOK_W:0]   c_add;
    logic [TOK_W:0]   p_add;
    logic [TOK_W:0]   c_new;
    logic [TOK_W:0]   e_new;
    logic [TOK_W:0]   spill;
    always_comb
    begin
        cacc  = {ctok_r, cfrac_r} + (TOK_W+QTM_FRAC_BITS+1)'(crate_r);
        pacc  = {etok_r, pfrac_r} + (TOK_W+QTM_FRAC_BITS+1)'(prate_r);
        c_add = cacc[TOK_W+QTM_FRAC_BITS:QTM_FRAC_BITS];
        p_add = pacc[TOK_W+QTM_FRAC_BITS:QTM_FRAC_BITS];
        spill = '0;
        c_new = c_add;
        e_new = {1'b0, etok_r};
        if (c_add > {1'b0, cbs_r})
        begin
            c_new = {1'b0, cbs_r};
            spill = c_add - {1'b0, cbs_r};
        end
        unique case (mode)
            QTM_M_SR: e_new = {1'b0, etok_r} + spill;
            QTM_M_TR: e_new = p_add;
            default:  e_new = {1'b0, etok_r};
        endcase
        if (e_new > {1'b0, ebs_r})
            e_new = {1'b0, ebs_r};
        if (take && qos_en)
        begin
            unique case (mode)
                QTM_M_TB: if (color == QTM_GREEN) c_new = c_new - {1'b0, plen};
                QTM_M_SR:
                begin
                    if (color == QTM_GREEN) c_new = c_new - {1'b0, plen};
                    if (color == QTM_YELLOW) e_new = e_new - {1'b0, plen};
                end
                QTM_M_TR:
                begin
                    if (color == QTM_GREEN) c_new = c_new - {1'b0, plen};
                    if (color != QTM_RED) e_new = e_new - {1'b0, plen};
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ctok_r  <= '0;
            etok_r  <= '0;
            cfrac_r <= '0;
            pfrac_r <= '0;
        end
        else
        begin
            ctok_r  <= c_new[TOK_W-1:0];
            etok_r  <= e_new[TOK_W-1:0];
            cfrac_r <= cacc[QTM_FRAC_BITS-1:0];
            pfrac_r <= pacc[QTM_FRAC_BITS-1:0];
        end
    end

    // result stage
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_res_valid <= 1'b0;
            o_res       <= '0;
        end
        else if (take)
        begin
            o_res_valid  <= 1'b1;
            o_res.len    <= i_pkt.len;
            o_res.color  <= qos_en ? color : QTM_GREEN;
            // queue index doubles as drop order downstream
            o_res.queue  <= (i_pkt.classed || !qos_en) ? i_pkt.class_q
                                                        : auto_queue(i_pkt, src);
            o_res.drop   <= res_drop;
            o_res.remark <= 1'b0;
            o_res.dscp   <= i_pkt.tos[7:2];
            if (qos_en && color == QTM_GREEN && ctrl_r[QTM_CTRL_GACT_BIT])
            begin
                o_res.remark <= 1'b1;
                o_res.dscp   <= ctrl_r[QTM_CTRL_GDSCP_LSB +: 6];
            end
            else if (qos_en && color == QTM_RED && ctrl_r[QTM_CTRL_RACT_BIT])
            begin
                o_res.remark <= 1'b1;
                o_res.dscp   <= ctrl_r[QTM_CTRL_RDSCP_LSB +: 6];
            end
            else if (qos_en && color == QTM_YELLOW)
            begin
                o_res.remark <= 1'b1;
                o_res.dscp   <= ctrl_r[QTM_CTRL_YDSCP_LSB +: 6];
            end
        end
        else if (i_res_ready)
        begin
            o_res_valid <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
            o_pkt_ready <= 1'b0;
        else
            o_pkt_ready <= !(take ? (!i_res_ready || hold) : (o_res_valid && !i_res_ready)) && !hold;
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            n_green_r <= '0;
            n_red_r   <= '0;
        end
        else if (take && qos_en)
        begin
            if (color == QTM_GREEN)
                n_green_r <= n_green_r + 32'h0000_0001;
            if (color == QTM_RED)
                n_red_r <= n_red_r + 32'h0000_0001;
        end
    end

    // apb slave: one wait-free access phase
    logic acc;
    assign acc = i_psel && i_penable;
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ctrl_r  <= QTM_CTRL_RST;
            crate_r <= QTM_RATE_RST;
            prate_r <= QTM_RATE_RST;
            cbs_r   <= TOK_W'(QTM_BS_RST);
            ebs_r   <= TOK_W'(QTM_BS_RST);
        end
        else if (acc && i_pwrite)
        begin
            unique case (i_paddr)
                QTM_CTRL_OFS:  ctrl_r  <= i_pwdata;
                QTM_CRATE_OFS: crate_r <= i_pwdata;
                QTM_PRATE_OFS: prate_r <= i_pwdata;
                QTM_CBS_OFS:   cbs_r   <= TOK_W'(i_pwdata);
                QTM_EBS_OFS:   ebs_r   <= TOK_W'(i_pwdata);
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_prdata  <= '0;
            o_pslverr <= 1'b0;
            o_pready  <= 1'b0;
        end
        else
        begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= 1'b0;
            o_prdata  <= '0;
            if (i_psel && !i_penable)
            begin
                unique case (i_paddr)
                    QTM_CTRL_OFS:  o_prdata <= ctrl_r;
                    QTM_CRATE_OFS: o_prdata <= crate_r;
                    QTM_PRATE_OFS: o_prdata <= prate_r;
                    QTM_CBS_OFS:   o_prdata <= 32'(cbs_r);
                    QTM_EBS_OFS:   o_prdata <= 32'(ebs_r);
                    QTM_CTOK_OFS:  o_prdata <= 32'(ctok_r);
                    QTM_ETOK_OFS:  o_prdata <= 32'(etok_r);
                    QTM_STAT_OFS:  o_prdata <= {n_red_r[15:0], n_green_r[15:0]};
                    default:       o_pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule : qtm_top
`default_nettype wire

//--- qtm_checker.sv
// checker: port-level properties of the queue map and traffic meter
`default_nettype none
module qtm_checker
    import qtm_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_nrst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pslverr,
    input wire logic        i_pkt_valid,
    input wire qtm_pkt_t    i_pkt,
    input wire logic        o_pkt_ready,
    input wire logic        o_res_valid,
    input wire qtm_res_t    o_res,
    input wire logic        i_res_ready
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    chk_apb_answer: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no register answer after setup");
    chk_apb_single: assert property (o_pready |=> !o_pready)
        else $error("register answer longer than one cycle");
    chk_err_read: assert property (o_pslverr |-> o_pready && (i_pwrite || o_prdata == 32'h0))
        else $error("error answer out of place or with data");
    chk_res_hold: assert property (o_res_valid && !i_res_ready |=> o_res_valid && $stable(o_res))
        else $error("result changed while stalled");
    chk_color_code: assert property (o_res_valid |-> o_res.color != 2'h3)
        else $error("illegal colour code");
    chk_drop_red: assert property (o_res_valid && o_res.drop |-> o_res.color == QTM_RED && !o_res.remark)
        else $error("drop on a packet that is not red");
    chk_yellow_mark: assert property (o_res_valid && o_res.color == QTM_YELLOW |-> o_res.remark && !o_res.drop)
        else $error("yellow packet not remarked");
    chk_green_pass: assert property (o_res_valid && o_res.color == QTM_GREEN |-> !o_res.drop)
        else $error("green packet dropped");
    chk_len_pair: assert property ($rose(o_res_valid) |-> o_res.len == $past(i_pkt.len))
        else $error("result length differs from descriptor");
    cover property (o_res_valid && o_res.color == QTM_YELLOW);
    cover property (o_res_valid && o_res.drop);
    cover property (o_res_valid && !i_res_ready);
    cover property (o_pslverr);
    cover property (i_pkt_valid && !o_pkt_ready && !o_res_valid);
endmodule : qtm_checker
bind qtm_top qtm_checker u_chk (.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_pkt_valid(i_pkt_valid), .i_pkt(i_pkt), .o_pkt_ready(o_pkt_ready),
    .o_res_valid(o_res_valid), .o_res(o_res), .i_res_ready(i_res_ready));
`default_nettype wire

//--- qtm_sink.sv
// egress queue model: takes results, stalling at random
`default_nettype none
module qtm_sink
    import qtm_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_nrst,
    input  wire logic i_res_valid,
    output var logic  o_res_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed = 32'hC7BB6DF6;
    // never ready in the first cycle of a result, so the source can tell when it was taken
    always @(posedge i_clock or negedge i_nrst)
        if (!i_nrst)
            o_res_ready <= 1'b0;
        else
            o_res_ready <= i_res_valid && !o_res_ready && ($random(seed) % 3 == 0);
endmodule : qtm_sink
`default_nettype wire

//--- qtm_test.sv
// self-checking bench: packet source, register master and result monitor
`default_nettype none
module qtm_test
    import qtm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0]  UPQ [8] = '{3'h2, 3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    localparam logic [2:0]  PRQ [8] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6, 3'h7, 3'h7};
    localparam logic [5:0]  DSC [9] = '{6'h08, 6'h10, 6'h18, 6'h20, 6'h28, 6'h2E, 6'h30,
                                        6'h38, 6'h00};
    localparam logic [2:0]  DSQ [9] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h6, 3'h6, 3'h7, 3'h7, 3'h0};
    localparam logic [15:0] LNS [6] = '{16'h00F9, 16'h00FA, 16'h044C, 16'h044D, 16'h0001,
                                        16'h05DC};
    localparam logic [2:0]  LNQ [6] = '{3'h5, 3'h3, 3'h3, 3'h2, 3'h5, 3'h2};
    logic        i_clock = 1'b0, i_nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, r;
    logic        pready, pslverr, pkt_ready, res_valid, res_ready, perr, pkt_valid = 1'b0;
    qtm_pkt_t    pkt = '0;
    qtm_res_t    res, e, g;
    qtm_res_t    exp_q [$];
    int          errors = 0, cmp_count = 0, cycles = 0, wait_n, seed = 32'hC7BB6DF6;

    qtm_top dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_pkt_valid(pkt_valid), .i_pkt(pkt),
        .o_pkt_ready(pkt_ready), .o_res_valid(res_valid), .o_res(res), .i_res_ready(res_ready));
    qtm_sink u_sink (.i_clock(i_clock), .i_nrst(i_nrst), .i_res_valid(res_valid),
        .o_res_ready(res_ready));

    always #5 i_clock = ~i_clock;

    task automatic results();
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want)
        begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask : check

    // idle edge at the end keeps two transfers from driving one signal in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        do @(posedge i_clock); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clock);
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        check(rd, want);
    endtask : rdc

    function automatic logic [31:0] cfg(input logic [1:0] m, s, input logic [2:0] f);
        return {6'h1C, 6'h12, 6'h0A, f, s, m, 1'b1};
    endfunction : cfg

    // dd is {drop, remark, dscp}; a new packet waits until the last result is gone
    task automatic send(input logic [2:0] u, input logic [7:0] t, input logic [15:0] l,
                        input logic [3:0] cl, input logic [2:0] q, input qtm_color_t c,
                        input logic [7:0] dd);
        exp_q.push_back(qtm_res_t'{q, c, dd[7], dd[6], dd[5:0], l});
        while (res_valid !== 1'b0) @(posedge i_clock);
        pkt <= '{u, t, l, cl[3], cl[2:0]};
        pkt_valid <= 1'b1;
        wait_n = 0;
        do begin @(posedge i_clock); wait_n++; end while (res_valid !== 1'b1);
        pkt_valid <= 1'b0;
    endtask : send

    // committed burst fixed at 0x3E8, above the other bucket for eb 0x1F4 and below it for 0x5DC, well inside link bandwidth
    task automatic fill(input logic [31:0] eb);
        apb(1'b1, QTM_CBS_OFS, 32'h3E8);
        apb(1'b1, QTM_EBS_OFS, eb);
        apb(1'b1, QTM_CRATE_OFS, 32'h0400_0000);
        apb(1'b1, QTM_PRATE_OFS, 32'h0400_0000);
        repeat (10) @(posedge i_clock);
        apb(1'b1, QTM_CRATE_OFS, 32'h0);
        apb(1'b1, QTM_PRATE_OFS, 32'h0);
        rdc(QTM_CTOK_OFS, 32'h3E8); // capped at burst
    endtask : fill

    always @(posedge i_clock)
        if (res_valid === 1'b1 && res_ready === 1'b1)
        begin
            e = exp_q.pop_front();
            g = res;
            if (!e.remark)
            begin
                e.dscp = 6'h00;
                g.dscp = 6'h00;
            end
            check(32'(g), 32'(e));
        end

    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            errors++;
            results();
        end
    end

    initial
    begin
        repeat (3) @(posedge i_clock);
        i_nrst <= 1'b1;
        rdc(QTM_CTRL_OFS, QTM_CTRL_RST);
        rdc(QTM_CRATE_OFS, QTM_RATE_RST);
        rdc(QTM_CBS_OFS, QTM_BS_RST);
        rdc(8'h40, 32'h0); // unmapped
        check({31'h0, perr}, 32'h1);
        apb(1'b1, QTM_CTRL_OFS, cfg(QTM_M_TB, QTM_S_UP, 3'h0));
        fill(32'h1F4);
        send(3'h3, 8'h00, 16'h0258, 4'h0, 3'h3, QTM_GREEN, 8'h00);
        send(3'h3, 8'h00, 16'h0258, 4'h0, 3'h3, QTM_RED, 8'h80);
        send(3'h3, 8'h00, 16'h0190, 4'h0, 3'h3, QTM_GREEN, 8'h00);
        rdc(QTM_CTOK_OFS, 32'h0);
        apb(1'b1, QTM_CTRL_OFS, cfg(QTM_M_TB, QTM_S_UP, 3'h4));
        send(3'h3, 8'h00, 16'h000A, 4'h0, 3'h3, QTM_RED, 8'h52);
        apb(1'b1, QTM_CTRL_OFS, cfg(QTM_M_TB, QTM_S_UP, 3'h1));
        apb(1'b1, QTM_CRATE_OFS, 32'h0000_4000);
        send(3'h3, 8'h00, 16'h0014, 4'h0, 3'h3, QTM_GREEN, 8'h00);
        check(32'(wait_n > 69 && wait_n < 86), 32'h1);
        apb(1'b1, QTM_CTRL_OFS, cfg(QTM_M_SR, QTM_S_UP, 3'h2));
        fill(32'h1F4);
        rdc(QTM_ETOK_OFS, 32'h1F4);
        send(3'h3, 8'h00, 16'h0384, 4'h0, 3'h3, QTM_GREEN, 8'h4A);
        send(3'h3, 8'h00, 16'h012C, 4'h0, 3'h3, QTM_YELLOW, 8'h5C);
        send(3'h3, 8'h00, 16'h00FA, 4'h0, 3'h3, QTM_RED, 8'h80);
        send(3'h3, 8'h00, 16'h00C8, 4'h0, 3'h3, QTM_YELLOW, 8'h5C);
        rdc(QTM_CTOK_OFS, 32'h64);
        rdc(QTM_ETOK_OFS, 32'h0);
        apb(1'b1, QTM_CTRL_OFS, cfg(QTM_M_TR, QTM_S_UP, 3'h0));
        fill(32'h5DC);
        rdc(QTM_ETOK_OFS, 32'h5DC);
        send(3'h3, 8'h00, 16'h0640, 4'h0, 3'h3, QTM_RED, 8'h80);
        send(3'h3, 8'h00, 16'h0384, 4'h0, 3'h3, QTM_GREEN, 8'h00);
        send(3'h3, 8'h00, 16'h01F4, 4'h0, 3'h3, QTM_YELLOW, 8'h5C);
        rdc(QTM_CTOK_OFS, 32'h64);
        rdc(QTM_ETOK_OFS, 32'h64);
        apb(1'b1, QTM_CBS_OFS, 32'h2800);
        apb(1'b1, QTM_CRATE_OFS, 32'h0400_0000);
        apb(1'b1, QTM_CTRL_OFS, cfg(QTM_M_TB, QTM_S_UP, 3'h0));
        for (int i = 0; i < 8; i++)
            send(3'(i), 8'($random(seed)), 16'h0040, 4'h0, UPQ[i], QTM_GREEN, 8'h00);
        send(3'h7, 8'h00, 16'h0040, 4'h9, 3'h1, QTM_GREEN, 8'h00); // classed
        apb(1'b1, QTM_CTRL_OFS, cfg(QTM_M_TB, QTM_S_PREC, 3'h0));
        for (int i = 0; i < 8; i++)
            send(3'($random(seed)), {3'(i), 5'($random(seed))}, 16'h0040, 4'h0, PRQ[i],
                 QTM_GREEN, 8'h00);
        apb(1'b1, QTM_CTRL_OFS, cfg(QTM_M_TB, QTM_S_DSCP, 3'h0));
        for (int i = 0; i < 9; i++)
        begin
            r = $random(seed);
            send(r[6:4], {DSC[i] | (i < 4 ? {3'h0, r[1:0], 1'b0} : 6'h00), r[3:2]}, 16'h0040,
                 4'h0, DSQ[i], QTM_GREEN, 8'h00);
        end
        apb(1'b1, QTM_CTRL_OFS, cfg(QTM_M_TB, QTM_S_LEN, 3'h0));
        for (int i = 0; i < 6; i++)
            send(3'($random(seed)), 8'($random(seed)), LNS[i], 4'h0, LNQ[i], QTM_GREEN,
                 8'h00);
        apb(1'b1, QTM_CTRL_OFS, 32'h0);
        send(3'h5, 8'hFF, 16'h1388, 4'h6, 3'h6, QTM_GREEN, 8'h00); // disabled
        while (exp_q.size() > 0) @(posedge i_clock);
        rdc(QTM_STAT_OFS, 32'h0004_0025); // 4 red, 37 green while enabled
        check({31'h0, pkt_ready}, 32'h1); // idle and unshaped
        results();
    end
endmodule : qtm_test
`default_nettype wire
